// >>> verilog/filter_debug_statistics_control.sv
// What this block does
// [R1] audio data register shows shared 24-bit sample, top eight bits zero
// [R2] inspect bit 7 exposes chosen accumulator; bit 6 enables single step
// [R3] bit 4 picks pre-filter accumulators when 0, array accumulators when 1
// [R4] channel field picks channel 0-7; 4-bit field sets counter a source
// [R5] second field sets counter b source; bit 15 holds counters cleared
// [R6] source 0000 counts samples; 1000-1111 count magnitude bit ranges
// [R7] source 0001 counts overflows; 0010 counts frequency errors
// [R8] both counter values readable as 32-bit read-only registers
// [R9] unused bits ignore writes, read zero; unknown sources hold counters
`timescale 1ns/1ns
`default_nettype none
module filter_debug_statistics_control #(
  parameter int COUNT_W = 32
) (
  input  wire logic                           mclk,
  input  wire logic                           reset_n,
  input  wire logic                           ce,
  input  wire logic [stat_pkg::ADDR_W-1:0]    reg_addr,
  input  wire logic                           reg_wr,
  input  wire logic [stat_pkg::DATA_W-1:0]    reg_wdata,
  input  wire logic                           reg_rd,
  output var  logic [stat_pkg::DATA_W-1:0]    reg_rdata_q,
  output var  logic                           reg_rvalid_q,
  input  wire logic                           sample_valid,
  input  wire logic [stat_pkg::SAMPLE_W-1:0]  shared_audio_sample,
  input  wire logic [stat_pkg::CHAN_W-1:0]    sample_channel,
  input  wire logic [stat_pkg::MAG_W-1:0]     sample_magnitude,
  input  wire logic                           overflow_event,
  input  wire logic                           freq_error_event,
  output var  logic [stat_pkg::ACC_IDX_W-1:0] accumulator_index_q,
  output var  logic                           array_acc_select_q,
  output var  logic                           single_step_on_q,
  output var  logic                           inspect_mode_on_q
);
  import stat_pkg::*;

  // ==========================================
  // control registers
  logic [DATA_W-1:0]   debug_ctrl_q;
  logic [DATA_W-1:0]   debug_ctrl_d;
  logic [DATA_W-1:0]   stat_ctrl_q;
  logic [DATA_W-1:0]   stat_ctrl_d;
  logic [SAMPLE_W-1:0] sample_q;
  logic [SAMPLE_W-1:0] sample_d;
  logic [DATA_W-1:0]   rdata_d;
  logic                rvalid_d;
  logic [COUNT_W-1:0]  count_a;
  logic [COUNT_W-1:0]  count_b;
  logic                chan_match;
  logic                step_a;
  logic                step_b;
  logic [SRC_W-1:0]    src_a;
  logic [SRC_W-1:0]    src_b;
  logic [ACC_IDX_W-1:0] accumulator_index_d;
  logic                array_acc_select_d;
  logic                single_step_on_d;
  logic                inspect_mode_on_d;

  // writable bits of each register
  localparam logic [31:0] DEBUG_CTRL_MASK = 32'h0000_00DF; // R9
  localparam logic [31:0] STAT_CTRL_MASK  = 32'h0000_8FF7; // R9

  // true when this cycle writes the given register
  // writes to read-only or unmapped indexes never hit
  function automatic logic write_hits(
    input logic              wr,
    input logic [ADDR_W-1:0] addr,
    input logic [ADDR_W-1:0] target
  );
    write_hits = wr && addr == target;
  endfunction

  // ==========================================
  // debug control register
  always_comb
  begin
    debug_ctrl_d = debug_ctrl_q;
    if (write_hits(reg_wr, reg_addr, DEBUG_CTRL_ADDR))
      debug_ctrl_d = reg_wdata & DEBUG_CTRL_MASK; // R2 R3 R9
  end

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
      debug_ctrl_q <= DEBUG_CTRL_RST;
    else if (ce)
      debug_ctrl_q <= debug_ctrl_d;
  end

  // ==========================================
  // statistics control register
  always_comb
  begin
    stat_ctrl_d = stat_ctrl_q;
    if (write_hits(reg_wr, reg_addr, STAT_CTRL_ADDR))
      stat_ctrl_d = reg_wdata & STAT_CTRL_MASK; // R4 R5 R9
  end

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
      stat_ctrl_q <= STAT_CTRL_RST;
    else if (ce)
      stat_ctrl_q <= stat_ctrl_d;
  end

  // ==========================================
  // shared audio sample capture
  // held between samples so software sees a stable word
  always_comb
  begin
    sample_d = sample_q;
    if (sample_valid)
      sample_d = shared_audio_sample; // R1
  end

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
      sample_q <= SAMPLE_RST;
    else if (ce)
      sample_q <= sample_d;
  end

  // ==========================================
  // debug control outputs
  // taken from the next value so pins follow a write at once
  always_comb
  begin
    accumulator_index_d = debug_ctrl_d[ACC_IDX_LSB +: ACC_IDX_W]; // R2
    array_acc_select_d  = debug_ctrl_d[FILTER_SEL_BIT]; // R3
    single_step_on_d    = debug_ctrl_d[STEP_BIT]; // R2
    inspect_mode_on_d   = debug_ctrl_d[INSPECT_BIT]; // R2
  end

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      accumulator_index_q <= '0;
      array_acc_select_q  <= 1'b0;
      single_step_on_q    <= 1'b0;
      inspect_mode_on_q   <= 1'b0;
    end
    else if (ce)
    begin
      accumulator_index_q <= accumulator_index_d;
      array_acc_select_q  <= array_acc_select_d;
      single_step_on_q    <= single_step_on_d;
      inspect_mode_on_q   <= inspect_mode_on_d;
    end
  end

  // ==========================================
  // statistics counters
  always_comb
  begin
    src_a      = stat_ctrl_q[SRC_A_LSB +: SRC_W];
    src_b      = stat_ctrl_q[SRC_B_LSB +: SRC_W];
    chan_match = sample_valid &&
                 sample_channel == stat_ctrl_q[CHAN_LSB +: CHAN_W]; // R4
    step_a     = count_hit(src_a, chan_match, overflow_event,
                           freq_error_event, sample_magnitude); // R6 R7 R9
    step_b     = count_hit(src_b, chan_match, overflow_event,
                           freq_error_event, sample_magnitude); // R6 R7 R9
  end

  // clear wins over any event of the same cycle
  stat_counter #(
    .WIDTH   (COUNT_W)
  ) u_count_a (
    .mclk    (mclk),
    .reset_n (reset_n),
    .ce      (ce),
    .clear   (stat_ctrl_q[CLEAR_BIT]), // R5
    .step    (step_a),
    .count_q (count_a)
  );

  stat_counter #(
    .WIDTH   (COUNT_W)
  ) u_count_b (
    .mclk    (mclk),
    .reset_n (reset_n),
    .ce      (ce),
    .clear   (stat_ctrl_q[CLEAR_BIT]), // R5
    .step    (step_b),
    .count_q (count_b)
  );

  // ==========================================
  // read path
  // a read in the cycle of a write returns the old value
  always_comb
  begin
    rdata_d  = reg_rdata_q;
    rvalid_d = reg_rd;
    if (reg_rd)
    begin
      unique case (reg_addr)
        AUDIO_DATA_ADDR: rdata_d = {8'h00, sample_q}; // R1
        DEBUG_CTRL_ADDR: rdata_d = debug_ctrl_q;
        STAT_CTRL_ADDR:  rdata_d = stat_ctrl_q;
        COUNT_A_ADDR:    rdata_d = DATA_W'(count_a); // R8
        COUNT_B_ADDR:    rdata_d = DATA_W'(count_b); // R8
        default:         rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      reg_rdata_q  <= '0;
      reg_rvalid_q <= 1'b0;
    end
    else if (ce)
    begin
      reg_rdata_q  <= rdata_d;
      reg_rvalid_q <= rvalid_d;
    end
  end

endmodule
`default_nettype wire

// >>> common/stat_pkg.sv
package stat_pkg;

  // ==========================================
  // register map
  localparam int          ADDR_W          = 12;
  localparam int          DATA_W          = 32;
  localparam logic [11:0] AUDIO_DATA_ADDR = 12'h503;
  localparam logic [11:0] DEBUG_CTRL_ADDR = 12'h504;
  localparam logic [11:0] STAT_CTRL_ADDR  = 12'h505;
  localparam logic [11:0] COUNT_A_ADDR    = 12'h50C;
  localparam logic [11:0] COUNT_B_ADDR    = 12'h50D;

  // ==========================================
  // field layout
  localparam int SAMPLE_W       = 24;
  localparam int ACC_IDX_LSB    = 0;
  localparam int ACC_IDX_W      = 4;
  localparam int FILTER_SEL_BIT = 4;
  localparam int STEP_BIT       = 6;
  localparam int INSPECT_BIT    = 7;
  localparam int CHAN_LSB       = 0;
  localparam int CHAN_W         = 3;
  localparam int SRC_A_LSB      = 4;
  localparam int SRC_B_LSB      = 8;
  localparam int SRC_W          = 4;
  localparam int CLEAR_BIT      = 15;
  localparam int MAG_W          = 8;

  // ==========================================
  // reset values
  localparam logic [31:0] DEBUG_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] STAT_CTRL_RST  = 32'h0000_0000;
  localparam logic [23:0] SAMPLE_RST     = 24'h00_0000;

  // ==========================================
  // counter source codes
  localparam logic [3:0] SRC_SAMPLE   = 4'h0;
  localparam logic [3:0] SRC_OVERFLOW = 4'h1;
  localparam logic [3:0] SRC_FREQ_ERR = 4'h2;

  // ==========================================
  // decides whether one counter steps this cycle
  function automatic logic count_hit(
    input logic [3:0] src,
    input logic       sample_ok,
    input logic       overflow,
    input logic       freq_err,
    input logic [7:0] mag
  );
    logic [7:0] mask;
    mask = 8'hFF << (3'd7 - src[2:0]);
    if (src[3])
      count_hit = sample_ok && |(mag & mask);
    else if (src == SRC_SAMPLE)
      count_hit = sample_ok;
    else if (src == SRC_OVERFLOW)
      count_hit = overflow;
    else if (src == SRC_FREQ_ERR)
      count_hit = freq_err;
    else
      count_hit = 1'b0;
  endfunction

endpackage

// >>> verilog/stat_counter.sv
`timescale 1ns/1ns
`default_nettype none
module stat_counter #(
  parameter int WIDTH = 32
) (
  input  wire logic             mclk,
  input  wire logic             reset_n,
  input  wire logic             ce,
  input  wire logic             clear,
  input  wire logic             step,
  output var  logic [WIDTH-1:0] count_q
);
  import stat_pkg::*;

  logic [WIDTH-1:0] count_d;

  always_comb
  begin
    count_d = count_q;
    if (clear)
      count_d = '0;
    else if (step)
      count_d = count_q + WIDTH'(1);
  end

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
      count_q <= '0;
    else if (ce)
      count_q <= count_d;
  end

endmodule
`default_nettype wire

// >>> bench/fdsc_chk.sv
`timescale 1ns/1ns
`default_nettype none
module fdsc_chk (
  input wire logic        mclk,
  input wire logic        reset_n,
  input wire logic        ce,
  input wire logic [11:0] reg_addr,
  input wire logic        reg_wr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata_q,
  input wire logic        reg_rvalid_q,
  input wire logic [3:0]  accumulator_index_q,
  input wire logic        array_acc_select_q,
  input wire logic        single_step_on_q,
  input wire logic        inspect_mode_on_q
);
  // ==========
  // debug control and read path checks
  wire wr_dbg = ce && reg_wr && reg_addr == 12'h504;
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  sequence s_rd_dbg;
    ce && reg_rd && !reg_wr && reg_addr == 12'h504 ##1 1'b1;
  endsequence
  AST_IDX: assert property (wr_dbg |=>
    accumulator_index_q == $past(reg_wdata[3:0])) else $error("index");
  AST_FSEL: assert property (wr_dbg |=>
    array_acc_select_q == $past(reg_wdata[4])) else $error("select");
  AST_STEP: assert property (wr_dbg |=>
    single_step_on_q == $past(reg_wdata[6])) else $error("step");
  AST_INSP: assert property (wr_dbg |=>
    inspect_mode_on_q == $past(reg_wdata[7])) else $error("inspect");
  AST_HOLD: assert property (!wr_dbg |=>
    $stable(accumulator_index_q)) else $error("index moved");
  AST_RVAL: assert property (ce && reg_rd |=> reg_rvalid_q)
    else $error("no rvalid");
  AST_STALE: assert property (!(ce && reg_rd) |=>
    $stable(reg_rdata_q)) else $error("rdata moved");
  AST_RDBACK: assert property (s_rd_dbg |-> reg_rvalid_q &&
    reg_rdata_q == {24'h0, inspect_mode_on_q, single_step_on_q, 1'b0,
    array_acc_select_q, accumulator_index_q}) else $error("readback");
endmodule
bind filter_debug_statistics_control fdsc_chk u_chk (
  .mclk(mclk), .reset_n(reset_n), .ce(ce), .reg_addr(reg_addr),
  .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
  .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q),
  .accumulator_index_q(accumulator_index_q),
  .array_acc_select_q(array_acc_select_q),
  .single_step_on_q(single_step_on_q),
  .inspect_mode_on_q(inspect_mode_on_q));
`default_nettype wire

// >>> bench/filter_debug_statistics_control_test.sv
`timescale 1ns/1ns
`default_nettype none
module filter_debug_statistics_control_test;
  logic        mclk = 0, reset_n = 0, ce = 1, reg_wr = 0, reg_rd = 0;
  logic        sample_valid = 0, overflow_event = 0, freq_error_event = 0;
  logic [11:0] reg_addr = 12'h000;
  logic [31:0] reg_wdata = 32'h0, reg_rdata_q;
  logic [23:0] shared_audio_sample = 24'hABCDEF;
  logic [2:0]  sample_channel = 3'h0;
  logic [7:0]  sample_magnitude = 8'h00;
  logic        reg_rvalid_q, array_acc_select_q;
  logic        single_step_on_q, inspect_mode_on_q;
  logic [3:0]  accumulator_index_q;
  int          miscompares = 0, num_checks = 0;
  filter_debug_statistics_control i_dut (
    .mclk(mclk), .reset_n(reset_n), .ce(ce), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q),
    .sample_valid(sample_valid), .sample_channel(sample_channel),
    .shared_audio_sample(shared_audio_sample),
    .sample_magnitude(sample_magnitude), .overflow_event(overflow_event),
    .freq_error_event(freq_error_event),
    .accumulator_index_q(accumulator_index_q),
    .array_acc_select_q(array_acc_select_q),
    .single_step_on_q(single_step_on_q),
    .inspect_mode_on_q(inspect_mode_on_q));
  initial forever #25 mclk = ~mclk;
  // ==========
  // bus and compare helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    // answer stands for one cycle after the taking edge
    #1;
    chk({31'h0, reg_rvalid_q}, 32'h1);
    chk(reg_rdata_q, e);
  endtask
  task automatic ctl(input logic [31:0] e);
    #1;
    chk({25'h0, inspect_mode_on_q, single_step_on_q, array_acc_select_q,
      accumulator_index_q}, e);
  endtask
  // {valid, channel, magnitude, overflow, freq error}
  task automatic ev(input logic [13:0] v);
    @(posedge mclk);
    {sample_valid, sample_channel, sample_magnitude, overflow_event,
      freq_error_event} <= v;
    @(posedge mclk);
    {sample_valid, overflow_event, freq_error_event} <= 3'b000;
  endtask
  // ==========
  // scenarios
  task automatic t_ctrl;
    wr(12'h504, 32'hFFFF_FFFF);
    rd(12'h504, 32'h0000_00DF);
    wr(12'h504, 32'h0000_00C5);
    ctl(32'h0000_0065);
    @(posedge mclk) ce <= 1'b0;
    wr(12'h504, 32'h0000_0010);
    ce <= 1'b1;
    ctl(32'h0000_0065);
    wr(12'h504, 32'h0000_0010);
    ctl(32'h0000_0010);
    $display("t_ctrl done");
  endtask
  task automatic t_stat;
    wr(12'h505, 32'hFFFF_FFFF);
    rd(12'h505, 32'h0000_8FF7);
    ev(14'b1_111_11111111_11);
    rd(12'h50C, 32'h0);
    rd(12'h777, 32'h0);
    $display("t_stat done");
  endtask
  task automatic t_evt;
    wr(12'h505, 32'h0000_0213);
    ev(14'b1_011_00000000_11);
    ev(14'b0_000_00000000_10);
    ev(14'b0_000_00000000_10);
    rd(12'h50C, 32'h3);
    rd(12'h50D, 32'h1);
    wr(12'h505, 32'h0000_0333);
    ev(14'b1_011_11111111_11);
    rd(12'h50C, 32'h3);
    wr(12'h505, 32'h0000_8000);
    rd(12'h50D, 32'h0);
    $display("t_evt done");
  endtask
  task automatic t_mag;
    wr(12'h503, 32'h1234_5678);
    wr(12'h505, 32'h0000_0F05);
    ev(14'b1_101_00000001_00);
    ev(14'b1_101_00000000_00);
    ev(14'b1_100_11111111_00);
    rd(12'h50C, 32'h2);
    rd(12'h50D, 32'h1);
    rd(12'h503, 32'h00AB_CDEF);
    @(posedge mclk) shared_audio_sample <= 24'h13_579B;
    rd(12'h503, 32'h00AB_CDEF);
    ev(14'b1_000_00000000_00);
    rd(12'h503, 32'h0013_579B);
    wr(12'h505, 32'h0000_8000);
    wr(12'h505, 32'h0000_0980);
    ev(14'b1_000_01000000_00);
    ev(14'b1_000_10000000_00);
    rd(12'h50C, 32'h1);
    rd(12'h50D, 32'h2);
    $display("t_mag done");
  endtask
  task automatic summarize;
    $display("checks=%0d miscompares=%0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    t_ctrl;
    t_stat;
    t_evt;
    t_mag;
    summarize;
  end
  initial
  begin
    #1000000;
    miscompares++;
    summarize;
  end
endmodule
`default_nettype wire
